//--- core/acrb_top.sv
// Configuration register bank with its serial host port.
// Assumes the serial pins are asynchronous to I_CLK_SYS and toggle well below its rate.
`timescale 1ns/10ps

// Contract
// - Soft reset bit restores defaults, then clears
// - Direction bit: 0 decrements, 1 increments
// - Setup low nibble mirrors high nibble
// - Non-mirrored setup write is discarded whole
// - Setup register resets to 0x3c
// - Bit 6 reserved zero (code lets a mirrored write set it), bit 4 reads one
// - Power field selects normal, sleep, power-down
// - Power register resets to zero
// - Streamed bytes go to adjacent address
// - Sleep and power-down keep register contents
// - Leaving power-down starts calibration, sleep not
module acrb_top #(
  parameter logic [7:0] PART_CLASS_ID = 8'h0a, // Arbitrary value
  parameter logic [7:0] PART_NUM_LO   = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_NUM_HI   = 8'h00, // Arbitrary value
  parameter logic [7:0] SI_REV        = 8'h00, // Arbitrary value
  parameter logic [7:0] MAKER_LO      = 8'h2e, // Arbitrary value
  parameter logic [7:0] MAKER_HI      = 8'h01  // Arbitrary value
) (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST_B,
  input  wire logic       I_SPI_SCLK,
  input  wire logic       I_SPI_CS_B,
  input  wire logic       I_SPI_SDI,
  input  wire logic [6:0] I_LINK_STATE,
  output logic            O_SPI_SDO,
  output logic            O_SPI_SDO_OE,
  output logic [1:0]      O_POWER_STATE,
  output logic            O_CAL_START
);

  logic       rst_meta_r;
  logic       rst_b_r;
  logic [2:0] sclk_r;
  logic [1:0] cs_b_r;
  logic [1:0] sdi_r;

  acrb_pkg::acrb_state_t       state_r;
  logic [4:0]                  cnt_r;
  logic [acrb_pkg::HDR_BITS-1:0] hdr_r;
  logic [6:0]                  din_r;
  logic [acrb_pkg::ADDR_W-1:0] addr_r;
  logic                        rnw_r;
  logic [7:0]                  dout_r;
  logic                        sdo_r;
  logic                        oe_r;
  logic [1:0]                  pd_prev_r;
  logic                        cal_r;
  logic [7:0]                  regs_r [acrb_pkg::MAP_DEPTH];

  // Reset released through two flops so release is clean to I_CLK_SYS
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_r <= 1'b0;
      rst_b_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b_r    <= rst_meta_r;
    end
  end

  // Only stage two and later feed logic; stage one is metastability guard
  // Third clock stage is only the edge detector's memory
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      sclk_r <= 3'h0;
    end else begin
      sclk_r <= {sclk_r[1:0], I_SPI_SCLK};
    end
  end

  // Select resets to idle high so no false frame start follows reset
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      cs_b_r <= 2'h3;
    end else begin
      cs_b_r <= {cs_b_r[0], I_SPI_CS_B};
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      sdi_r <= 2'h0;
    end else begin
      sdi_r <= {sdi_r[0], I_SPI_SDI};
    end
  end

  wire sclk_rise = sclk_r[1] & ~sclk_r[2];
  wire sclk_fall = ~sclk_r[1] & sclk_r[2];
  wire cs_act    = ~cs_b_r[1];
  wire sdi_s     = sdi_r[1];

  function automatic logic [7:0] rst_val(input logic [6:0] idx);
    unique case (idx)
      acrb_pkg::OFS_INTF_SETUP: rst_val = acrb_pkg::RST_INTF_SETUP;
      acrb_pkg::OFS_SER_LEVEL:  rst_val = acrb_pkg::RST_SER_LEVEL;
      acrb_pkg::OFS_OPMODE_ONE: rst_val = acrb_pkg::RST_OPMODE_ONE;
      acrb_pkg::OFS_OPMODE_TWO: rst_val = acrb_pkg::RST_OPMODE_TWO;
      acrb_pkg::OFS_LINK_CTRL1: rst_val = acrb_pkg::RST_LINK_CTRL1;
      acrb_pkg::OFS_RAMP_LO:    rst_val = acrb_pkg::RST_RAMP_LO;
      // Stored registers whose default is all zero
      acrb_pkg::OFS_POWER_CFG,
      acrb_pkg::OFS_PART_CLASS,
      acrb_pkg::OFS_IMB_TRIM,
      acrb_pkg::OFS_OVR_ENABLE,
      acrb_pkg::OFS_OVERRANGE_HOLD,
      acrb_pkg::OFS_OVR_THRESH,
      acrb_pkg::OFS_OFFSET_CORR,
      acrb_pkg::OFS_SER_DRIVE,
      acrb_pkg::OFS_LINK_CTRL2,
      acrb_pkg::OFS_RAMP_HI,
      acrb_pkg::OFS_LANE_POL:   rst_val = acrb_pkg::RST_ZERO;
      default:                  rst_val = acrb_pkg::RST_ZERO;
    endcase
  endfunction

  // Unmapped entries get no write lanes, so they stay at zero
  function automatic logic [7:0] wr_mask(input logic [6:0] idx);
    unique case (idx)
      acrb_pkg::OFS_INTF_SETUP:  wr_mask = acrb_pkg::WM_INTF_SETUP;
      acrb_pkg::OFS_PART_CLASS:  wr_mask = acrb_pkg::WM_PART_CLASS;
      acrb_pkg::OFS_POWER_CFG,
      acrb_pkg::OFS_SER_LEVEL,
      acrb_pkg::OFS_OPMODE_ONE,
      acrb_pkg::OFS_OPMODE_TWO,
      acrb_pkg::OFS_IMB_TRIM,
      acrb_pkg::OFS_OVR_ENABLE,
      acrb_pkg::OFS_OVERRANGE_HOLD,
      acrb_pkg::OFS_OVR_THRESH,
      acrb_pkg::OFS_OFFSET_CORR,
      acrb_pkg::OFS_SER_DRIVE,
      acrb_pkg::OFS_LINK_CTRL1,
      acrb_pkg::OFS_LINK_CTRL2,
      acrb_pkg::OFS_RAMP_LO,
      acrb_pkg::OFS_RAMP_HI,
      acrb_pkg::OFS_LANE_POL:    wr_mask = acrb_pkg::WM_FULL;
      default:                   wr_mask = acrb_pkg::WM_NONE;
    endcase
  endfunction

  function automatic logic [7:0] rd_val(input logic [acrb_pkg::ADDR_W-1:0] a);
    logic [6:0] idx;
    idx = a[acrb_pkg::IDX_W-1:0];
    if (a[acrb_pkg::ADDR_W-1:acrb_pkg::IDX_W] != '0) begin
      rd_val = 8'h00;
    end else begin
      unique case (idx)
        acrb_pkg::OFS_PART_CLASS:  rd_val = {regs_r[idx][7:4], PART_CLASS_ID[3:0]};
        acrb_pkg::OFS_PART_NUM_LO: rd_val = PART_NUM_LO;
        acrb_pkg::OFS_PART_NUM_HI: rd_val = PART_NUM_HI;
        acrb_pkg::OFS_SI_REV:      rd_val = SI_REV;
        acrb_pkg::OFS_MAKER_LO:    rd_val = MAKER_LO;
        acrb_pkg::OFS_MAKER_HI:    rd_val = MAKER_HI;
        acrb_pkg::OFS_LINK_STATE:  rd_val = {1'b0, I_LINK_STATE};
        // Holes decode to zero instead of trusting the unused array words
        acrb_pkg::OFS_INTF_SETUP,
        acrb_pkg::OFS_POWER_CFG,
        acrb_pkg::OFS_SER_LEVEL,
        acrb_pkg::OFS_OPMODE_ONE,
        acrb_pkg::OFS_OPMODE_TWO,
        acrb_pkg::OFS_IMB_TRIM,
        acrb_pkg::OFS_OVR_ENABLE,
        acrb_pkg::OFS_OVERRANGE_HOLD,
        acrb_pkg::OFS_OVR_THRESH,
        acrb_pkg::OFS_OFFSET_CORR,
        acrb_pkg::OFS_SER_DRIVE,
        acrb_pkg::OFS_LINK_CTRL1,
        acrb_pkg::OFS_LINK_CTRL2,
        acrb_pkg::OFS_RAMP_LO,
        acrb_pkg::OFS_RAMP_HI,
        acrb_pkg::OFS_LANE_POL:    rd_val = regs_r[idx];
        default:                   rd_val = 8'h00;
      endcase
    end
  endfunction

  wire [acrb_pkg::HDR_BITS-1:0] hdr_full = {hdr_r[acrb_pkg::HDR_BITS-2:0], sdi_s};
  wire [acrb_pkg::ADDR_W-1:0]   hdr_addr = hdr_full[acrb_pkg::ADDR_W-1:0];
  wire                          hdr_rnw  = hdr_full[acrb_pkg::CMD_POS];
  wire [7:0]                    wr_byte  = {din_r, sdi_s};
  wire [6:0]                    wr_idx   = addr_r[acrb_pkg::IDX_W-1:0];
  wire in_map   = addr_r[acrb_pkg::ADDR_W-1:acrb_pkg::IDX_W] == '0;
  wire hdr_shift = cs_act & sclk_rise & (state_r == acrb_pkg::ST_HDR);
  wire din_shift = cs_act & sclk_rise & (state_r == acrb_pkg::ST_DATA);
  wire hdr_done  = hdr_shift & (cnt_r == acrb_pkg::HDR_LAST);
  wire byte_done = din_shift & (cnt_r == acrb_pkg::DATA_LAST);
  wire [4:0] cnt_nxt = 5'(cnt_r + 1'b1);
  wire mirror_ok = wr_byte[3:0] == {wr_byte[4], wr_byte[5], wr_byte[6], wr_byte[7]};
  wire is_setup  = wr_idx == acrb_pkg::OFS_INTF_SETUP;
  wire wr_fire   = byte_done & ~rnw_r & in_map & (~is_setup | mirror_ok);
  wire soft_rst  = wr_fire & is_setup & wr_byte[acrb_pkg::BIT_SOFT_RESET];
  wire stream_address_direction    = regs_r[acrb_pkg::OFS_INTF_SETUP][acrb_pkg::BIT_STREAM_DIR];
  wire [acrb_pkg::ADDR_W-1:0] addr_next = stream_address_direction ?
    acrb_pkg::ADDR_W'(addr_r + 1'b1) : acrb_pkg::ADDR_W'(addr_r - 1'b1);
  wire [1:0] pd_now = regs_r[acrb_pkg::OFS_POWER_CFG][1:0];

  // Reset, soft reset and writes only; power states never touch this array
  genvar gi;
  generate
    for (gi = 0; gi < acrb_pkg::MAP_DEPTH; gi++) begin : g_reg
      localparam logic [6:0] IDX = 7'(gi);
      always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
        if (!rst_b_r) begin
          regs_r[gi] <= rst_val(IDX);
        end else if (soft_rst) begin
          regs_r[gi] <= rst_val(IDX);
        end else if (wr_fire && wr_idx == IDX) begin
          // Only bit 4 of setup stays out of the mask (read-one); bit 7 is masked in but self-clears as soft reset wins
          regs_r[gi] <= (regs_r[gi] & ~wr_mask(IDX)) | (wr_byte & wr_mask(IDX));
        end
      end
    end
  endgenerate

  // Serial framing; raised chip select aborts any partial command
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      state_r <= acrb_pkg::ST_IDLE;
      cnt_r   <= 5'h00;
    end else if (!cs_act) begin
      state_r <= acrb_pkg::ST_IDLE;
      cnt_r   <= 5'h00;
    end else begin
      unique case (state_r)
        acrb_pkg::ST_IDLE: begin
          state_r <= acrb_pkg::ST_HDR;
          cnt_r   <= 5'h00;
        end
        acrb_pkg::ST_HDR: begin
          if (hdr_done) begin
            state_r <= acrb_pkg::ST_DATA;
            cnt_r   <= 5'h00;
          end else if (sclk_rise) begin
            cnt_r <= cnt_nxt;
          end
        end
        acrb_pkg::ST_DATA: begin
          if (byte_done) begin
            cnt_r <= 5'h00;
          end else if (sclk_rise) begin
            cnt_r <= cnt_nxt;
          end
        end
        default: begin
          state_r <= acrb_pkg::ST_IDLE;
          cnt_r   <= 5'h00;
        end
      endcase
    end
  end

  // Header shifter moves only while the header is clocked in
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      hdr_r <= '0;
    end else if (hdr_shift) begin
      hdr_r <= hdr_full;
    end
  end

  // Data shifter; a stream simply keeps shifting byte after byte
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      din_r <= 7'h00;
    end else if (din_shift) begin
      din_r <= wr_byte[6:0];
    end
  end

  // Address advances after every byte of a stream, read or write
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      addr_r <= '0;
      rnw_r  <= 1'b0;
    end else if (hdr_done) begin
      addr_r <= hdr_addr;
      rnw_r  <= hdr_rnw;
    end else if (byte_done) begin
      addr_r <= addr_next;
    end
  end

  wire [7:0] rd_hdr_val  = rd_val(hdr_addr);
  wire [7:0] rd_next_val = rd_val(addr_next);
  // A freshly loaded MSB must survive the fall that follows its load
  wire       sdo_shift   = sclk_fall & oe_r & (cnt_r != 5'h00);

  // Read data leaves MSB first; later bits follow on falling edges
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      dout_r <= 8'h00;
      sdo_r  <= 1'b0;
    end else if (!cs_act) begin
      sdo_r <= 1'b0;
    end else if (hdr_done && hdr_rnw) begin
      dout_r <= rd_hdr_val;
      sdo_r  <= rd_hdr_val[7];
    end else if (byte_done && rnw_r) begin
      dout_r <= rd_next_val;
      sdo_r  <= rd_next_val[7];
    end else if (sdo_shift) begin
      dout_r <= {dout_r[6:0], 1'b0};
      sdo_r  <= dout_r[6];
    end
  end

  // Output driven only from header end of a read until deselect
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      oe_r <= 1'b0;
    end else if (!cs_act) begin
      oe_r <= 1'b0;
    end else if (hdr_done && hdr_rnw) begin
      oe_r <= 1'b1;
    end
  end

  // Only a power-down exit recalibrates; sleep exit is the fast path
  always_ff @(posedge I_CLK_SYS or negedge rst_b_r) begin
    if (!rst_b_r) begin
      pd_prev_r <= acrb_pkg::PD_NORMAL;
      cal_r     <= 1'b0;
    end else begin
      pd_prev_r <= pd_now;
      cal_r     <= (pd_prev_r == acrb_pkg::PD_OFF) && (pd_now == acrb_pkg::PD_NORMAL);
    end
  end

  assign O_SPI_SDO     = sdo_r;
  assign O_SPI_SDO_OE  = oe_r;
  assign O_POWER_STATE = pd_now;
  assign O_CAL_START   = cal_r;

endmodule

//--- core/acrb_pkg.sv
// Address map, reset values and field positions of the configuration bank.
// Assumes byte-wide registers behind a 15-bit serial address.
package acrb_pkg;
  localparam int ADDR_W    = 15;
  localparam int IDX_W     = 7;
  localparam int MAP_DEPTH = 128;
  localparam int HDR_BITS  = 16;
  localparam int DATA_BITS = 8;

  localparam logic [4:0] HDR_LAST  = 5'h0f;
  localparam logic [4:0] DATA_LAST = 5'h07;
  localparam int         CMD_POS   = 15;

  localparam logic [6:0] OFS_INTF_SETUP   = 7'h00;
  localparam logic [6:0] OFS_POWER_CFG    = 7'h02;
  localparam logic [6:0] OFS_PART_CLASS   = 7'h03;
  localparam logic [6:0] OFS_PART_NUM_LO  = 7'h04;
  localparam logic [6:0] OFS_PART_NUM_HI  = 7'h05;
  localparam logic [6:0] OFS_SI_REV       = 7'h06;
  localparam logic [6:0] OFS_MAKER_LO     = 7'h0c;
  localparam logic [6:0] OFS_MAKER_HI     = 7'h0d;
  localparam logic [6:0] OFS_SER_LEVEL    = 7'h10;
  localparam logic [6:0] OFS_OPMODE_ONE   = 7'h12;
  localparam logic [6:0] OFS_OPMODE_TWO   = 7'h13;
  localparam logic [6:0] OFS_IMB_TRIM     = 7'h14;
  localparam logic [6:0] OFS_OVR_ENABLE   = 7'h3a;
  localparam logic [6:0] OFS_OVERRANGE_HOLD     = 7'h3b;
  localparam logic [6:0] OFS_OVR_THRESH   = 7'h3c;
  localparam logic [6:0] OFS_OFFSET_CORR  = 7'h3d;
  localparam logic [6:0] OFS_SER_DRIVE    = 7'h47;
  localparam logic [6:0] OFS_LINK_CTRL1   = 7'h60;
  localparam logic [6:0] OFS_LINK_CTRL2   = 7'h61;
  localparam logic [6:0] OFS_RAMP_LO      = 7'h62;
  localparam logic [6:0] OFS_RAMP_HI      = 7'h63;
  localparam logic [6:0] OFS_LANE_POL     = 7'h64;
  localparam logic [6:0] OFS_LINK_STATE   = 7'h6c;

  localparam logic [7:0] RST_INTF_SETUP   = 8'h3c;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_SER_LEVEL    = 8'h01;
  localparam logic [7:0] RST_OPMODE_ONE   = 8'hc1;
  localparam logic [7:0] RST_OPMODE_TWO   = 8'h20;
  localparam logic [7:0] RST_LINK_CTRL1   = 8'h7f;
  localparam logic [7:0] RST_RAMP_LO      = 8'h01;

  localparam logic [7:0] WM_INTF_SETUP    = 8'hef;
  localparam logic [7:0] WM_PART_CLASS    = 8'hf0;
  localparam logic [7:0] WM_FULL          = 8'hff;
  localparam logic [7:0] WM_NONE          = 8'h00;

  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_STREAM_DIR = 5;

  localparam logic [1:0] PD_NORMAL   = 2'h0;
  localparam logic [1:0] PD_RESERVED = 2'h1;
  localparam logic [1:0] PD_SLEEP    = 2'h2;
  localparam logic [1:0] PD_OFF      = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_DATA = 2'b10
  } acrb_state_t;
endpackage

//--- sim/acrb_chk_sva.sv
// Port checker for the configuration bank.
// Assumes a bind onto acrb_top; one clock domain.
`timescale 1ns/10ps
module acrb_chk (
  input wire logic       I_CLK_SYS,
  input wire logic       I_RST_B,
  input wire logic       I_SPI_CS_B,
  input wire logic       O_SPI_SDO_OE,
  input wire logic [1:0] O_POWER_STATE,
  input wire logic       O_CAL_START
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);
  sequence s_wake_off;
    (O_POWER_STATE == 2'h0) && ($past(O_POWER_STATE) == 2'h3);
  endsequence
  sequence s_wake_sleep;
    (O_POWER_STATE == 2'h0) && ($past(O_POWER_STATE) == 2'h2);
  endsequence
  chk_reset_normal: assert property ($rose(I_RST_B) |-> (O_POWER_STATE == 2'h0) [*4])
    else $error("power state not normal after reset");
  chk_wake_cal: assert property (s_wake_off |-> ##[0:1] O_CAL_START)
    else $error("no calibration on leaving power-down");
  chk_sleep_nocal: assert property (s_wake_sleep |-> !O_CAL_START [*2])
    else $error("calibration on leaving sleep");
  chk_cal_single: assert property (O_CAL_START |=> !O_CAL_START)
    else $error("calibration pulse too long");
  chk_cal_cause: assert property (O_CAL_START |-> O_POWER_STATE == 2'h0 &&
    ($past(O_POWER_STATE) == 2'h3 || $past(O_POWER_STATE, 2) == 2'h3))
    else $error("calibration without power-down exit");
  // Power only moves on a host write, so select was low just before
  chk_power_by_host: assert property ($changed(O_POWER_STATE) |-> !$past(I_SPI_CS_B, 6))
    else $error("power state moved without host access");
  chk_oe_release: assert property ($rose(I_SPI_CS_B) |-> ##[1:8] !O_SPI_SDO_OE)
    else $error("read output kept after deselect");
  chk_oe_held: assert property ($fell(O_SPI_SDO_OE) |-> I_SPI_CS_B && $past(I_SPI_CS_B))
    else $error("read output dropped inside a frame");
endmodule

//--- sim/acrb_host.sv
// Host serial controller model: select, serial clock, data in and out.
// Assumes the bench clock; each serial clock half spans HALF system clocks.
`timescale 1ns/10ps
module acrb_host #(
  parameter int HALF = 10
) (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_sclk,
  output logic      o_cs_b,
  output logic      o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sdi  = 1'b0;
  end
  // Words low-justified, first byte highest; callers keep setup writes
  // mirrored (bar the 0x1c discard check) with bit 4 set and bit 6 clear power top bits zero
  task automatic xfer(input logic rd, input logic [14:0] adr, input int n,
                      input logic [31:0] wd, output logic [31:0] q);
    logic [15:0] hdr;
    hdr = {rd, adr};
    q = '0;
    @(posedge i_clk);
    o_cs_b <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < 16 + 8 * n; i++) begin
      o_sdi <= (i < 16) ? hdr[15 - i] : wd[8 * n + 15 - i];
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b1;
      if (i >= 16) q = {q[30:0], i_sdo_oe ? i_sdo : 1'bx};
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge i_clk);
    o_cs_b <= 1'b1;
    // Released data line must not keep its last level
    o_sdi  <= ~o_sdi;
    repeat (2 * HALF) @(posedge i_clk);
  endtask
endmodule

//--- sim/acrb_top_tb.sv
// Self-checking bench for the configuration bank over its serial port.
// Assumes the host model acrb_host and the checker acrb_chk.
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("wrong value %s exp %h got %h", nm, exp, got); \
    end \
  end
module acrb_top_tb;
  logic        clk;
  logic        rst_b;
  logic        sclk;
  logic        cs_b;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic [1:0]  pwr;
  logic        cal;
  logic [31:0] q;
  int          err_count;
  int          checked;
  int          cal_count;
  logic [14:0] adrs [12] = '{0, 2, 3, 4, 'h10, 'h12, 'h13, 'h3c, 'h60, 'h61, 'h62, 'h6c};
  logic [7:0]  dflt [12] = '{'h3c, 0, 'h0a, 'h6b, 1, 'hc1, 'h20, 0, 'h7f, 0, 1, 'h5a};
  logic [1:0]  pcode [6] = '{2, 0, 3, 0, 1, 0};
  int          pcal [6]  = '{0, 0, 0, 1, 1, 1};
  acrb_top #(.PART_NUM_LO(8'h6b)) u_acrb_top ( // Arbitrary identity value
    .I_CLK_SYS     (clk),
    .I_RST_B       (rst_b),
    .I_SPI_SCLK    (sclk),
    .I_SPI_CS_B    (cs_b),
    .I_SPI_SDI     (sdi),
    .I_LINK_STATE  (7'h5a),
    .O_SPI_SDO     (sdo),
    .O_SPI_SDO_OE  (sdo_oe),
    .O_POWER_STATE (pwr),
    .O_CAL_START   (cal)
  );
  acrb_host #(.HALF(10)) u_acrb_host (
    .i_clk    (clk),
    .i_sdo    (sdo),
    .i_sdo_oe (sdo_oe),
    .o_sclk   (sclk),
    .o_cs_b   (cs_b),
    .o_sdi    (sdi)
  );
  always #2 clk = ~clk;
  always @(posedge clk) cal_count <= cal_count + int'(cal === 1'b1);
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_acrb_host.xfer(1'b0, a, 1, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    u_acrb_host.xfer(1'b1, a, 1, 32'h0, q);
    `CHK($sformatf("reg %h", a), e, q[7:0])
  endtask
  task automatic print_verdict;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    err_count = 0;
    checked = 0;
    cal_count = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    foreach (adrs[i]) rd(adrs[i], dflt[i]);
    wr(15'h0001, 8'hff);
    rd(15'h0001, 8'h00);
    wr(15'h4000, 8'hff);
    rd(15'h4000, 8'h00);
    wr(15'h0004, 8'hff);
    rd(15'h0004, 8'h6b);
    wr(15'h0000, 8'h1c);
    rd(15'h0000, 8'h3c);
    wr(15'h0000, 8'h18);
    rd(15'h0000, 8'h18);
    u_acrb_host.xfer(1'b0, 15'h0014, 3, 32'h00a1b2c3, q);
    u_acrb_host.xfer(1'b1, 15'h0014, 3, 32'h0, q);
    `CHK("down stream", 32'h00a1b2c3, q)
    wr(15'h0000, 8'h3c);
    u_acrb_host.xfer(1'b1, 15'h0012, 3, 32'h0, q);
    `CHK("up stream", 32'h00c3b2a1, q)
    foreach (pcode[i]) begin
      wr(15'h0002, {6'h00, pcode[i]});
      `CHK("power state", pcode[i], pwr)
      rd(15'h0014, 8'ha1);
      `CHK("cal count", pcal[i], cal_count)
    end
    wr(15'h0002, 8'h03);
    wr(15'h0000, 8'hbd);
    rd(15'h0000, 8'h3c);
    rd(15'h0014, 8'h00);
    `CHK("power after soft reset", 2'h0, pwr)
    print_verdict();
  end
endmodule
bind acrb_top acrb_chk u_acrb_chk (
  .I_CLK_SYS     (I_CLK_SYS),
  .I_RST_B       (I_RST_B),
  .I_SPI_CS_B    (I_SPI_CS_B),
  .O_SPI_SDO_OE  (O_SPI_SDO_OE),
  .O_POWER_STATE (O_POWER_STATE),
  .O_CAL_START   (O_CAL_START)
);
